// ==== rtl/uim_pkg.sv ====
// Package for the USB interface machine status and flag block.
// Assumes a 32-bit word register port with byte offsets.
package uim_pkg;

  // Register byte offsets
  localparam logic [7:0] OTG_STATUS_OFS  = 8'h14;
  localparam logic [7:0] SERIAL_CTRL_OFS = 8'h18;
  localparam logic [7:0] EVENT_FLAGS_OFS = 8'h1c;
  localparam logic [7:0] HOLD_SEL_OFS    = 8'h20;
  localparam logic [7:0] PORT_MASK_OFS   = 8'h24;
  localparam logic [7:0] FRAME_COUNT_OFS = 8'h28;
  localparam logic [7:0] LAST_PID_OFS    = 8'h2c;
  localparam logic [7:0] LAST_EP_OFS     = 8'h30;
  localparam logic [7:0] EP_MARK_OFS     = 8'h34;
  localparam logic [7:0] SESS_MASK_OFS   = 8'h38;
  localparam logic [7:0] PWR_SIG_OFS     = 8'h3c;

  // Signal flag positions
  localparam int NUM_FLAGS      = 7;
  localparam int TOKEN_FLAG_BIT = 6;
  localparam int SE0_FLAG_BIT   = 5;
  localparam int K_FLAG_BIT     = 4;
  localparam int J_FLAG_BIT     = 3;
  localparam int CRC_FLAG_BIT   = 2;
  localparam int RXACT_FLAG_BIT = 1;
  localparam int RXERR_FLAG_BIT = 0;

  // Serial line control positions
  localparam int RX_DIFF_BIT   = 6;
  localparam int RX_DM_BIT     = 5;
  localparam int RX_DP_BIT     = 4;
  localparam int TX_SE0_BIT    = 3;
  localparam int TX_DATA_BIT   = 2;
  localparam int TX_EN_LOW_BIT = 1;
  localparam int FSLS_BIT      = 0;
  localparam int SERIAL_CTRL_W = 4;
  localparam logic [3:0] SERIAL_CTRL_RESET = 4'h2;

  // Field widths
  localparam int OTG_STATUS_W = 6;
  localparam int MASK_W       = 8;
  localparam int NUM_PORTS    = 4;
  localparam int FRAME_W      = 11;
  localparam int PID_W        = 4;
  localparam int EP_W         = 4;
  localparam int EP_VALID_BIT = 4;
  localparam int EP_MARK_W    = 16;
  localparam int PWR_SIG_W    = 9;
  localparam int PWR_VALID_BIT = 8;

  // Marked endpoints are delivered with this value ORed in
  localparam logic [4:0] EP_MARK_OR = 5'h10;

  // Decoded line state codes
  localparam logic [1:0] LS_SE0 = 2'h0;
  localparam logic [1:0] LS_J   = 2'h1;
  localparam logic [1:0] LS_K   = 2'h2;
  localparam logic [1:0] LS_NONE = 2'h3;

endpackage : uim_pkg

// ==== rtl/uim_flag_cell.sv ====
// One signal flag with optional hold and write-one clear.
// Assumes hit_i and the strobes are on clk_i already.
`timescale 1ns/100ps
`default_nettype none
module uim_flag_cell #(
  parameter bit LEVEL = 1'b0
) (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic hit_i,
  input  wire logic sticky_i,
  input  wire logic pkt_start_i,
  input  wire logic clear_i,
  output logic      flag_o
);

  logic flag_q;
  logic flag_d;
  logic drop;

  // A new hit beats a clear in the same cycle
  assign drop   = clear_i | (~sticky_i & pkt_start_i);
  assign flag_d = (LEVEL && !sticky_i) ? hit_i
                                       : (hit_i | (flag_q & ~drop));

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flag_o = flag_q;

endmodule : uim_flag_cell
`default_nettype wire

// ==== rtl/uim_status_flags.sv ====
// Status, flag, mask and frame registers of the USB interface machine.
// Assumes the packet decoder strobes are on clk_i; transceiver levels
// are asynchronous and are synchronised here.
`timescale 1ns/100ps
`default_nettype none
module uim_status_flags
  import uim_pkg::*;
(
  input  wire logic                    clk_i,
  input  wire logic                    reset_i,
  input  wire logic [7:0]              reg_addr_i,
  input  wire logic [31:0]             reg_wdata_i,
  input  wire logic                    reg_wr_i,
  input  wire logic                    reg_rd_i,
  output logic      [31:0]             reg_rdata_o,
  output logic                         reg_rvalid_o,
  input  wire logic [OTG_STATUS_W-1:0] otg_status_i,
  input  wire logic                    rx_diff_i,
  input  wire logic                    rx_dm_i,
  input  wire logic                    rx_dp_i,
  input  wire logic [1:0]              line_state_i,
  input  wire logic                    rx_active_i,
  input  wire logic                    rx_error_i,
  input  wire logic                    pkt_start_i,
  input  wire logic                    token_ok_i,
  input  wire logic                    crc16_fail_i,
  input  wire logic                    pid_valid_i,
  input  wire logic [PID_W-1:0]        pid_i,
  input  wire logic                    ep_valid_i,
  input  wire logic [EP_W-1:0]         ep_i,
  input  wire logic                    sof_valid_i,
  input  wire logic [FRAME_W-1:0]      sof_frame_i,
  output logic                         tx_se0_o,
  output logic                         tx_data_o,
  output logic                         tx_enable_n_o,
  output logic                         fsls_serial_o,
  output logic                         port_1n_o,
  output logic                         port_1o_o,
  output logic                         port_1p_o,
  output logic                         port_extra_o,
  output logic      [EP_W:0]           rx_ep_o,
  output logic                         rx_ep_valid_o,
  output logic                         pwr_signal_valid_o,
  output logic      [7:0]              pwr_signal_value_o
);

  localparam int SYNC_W = OTG_STATUS_W + 7;
  // Line state resets to no symbol, so no false SE0 flag after reset
  localparam logic [SYNC_W-1:0] SYNC_IDLE = SYNC_W'({LS_NONE, 2'b00});

  // Two-stage synchroniser for all transceiver levels
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic [SYNC_W-1:0] sync_in;

  assign sync_in = {otg_status_i, rx_diff_i, rx_dm_i, rx_dp_i,
                    line_state_i, rx_active_i, rx_error_i};

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sync1_q <= SYNC_IDLE;
      sync2_q <= SYNC_IDLE;
    end else begin
      sync1_q <= sync_in;
      sync2_q <= sync1_q;
    end
  end

  wire [OTG_STATUS_W-1:0] otg_s     = sync2_q[SYNC_W-1:7];
  wire [2:0]              rx_lvl_s  = sync2_q[6:4];
  wire [1:0]              ls_s      = sync2_q[3:2];
  wire                    rx_act_s  = sync2_q[1];
  wire                    rx_err_s  = sync2_q[0];

  // Register state
  logic [SERIAL_CTRL_W-1:0]    serial_q;
  logic [NUM_FLAGS-1:0]        hold_q;
  logic [NUM_PORTS*MASK_W-1:0] mask_q;
  logic [FRAME_W-1:0]          frame_q;
  logic [PID_W-1:0]            pid_q;
  logic [EP_W:0]               last_ep_q;
  logic [EP_MARK_W-1:0]        mark_q;
  logic [31:0]                 sess_mask_q;
  logic [PWR_SIG_W-1:0]        pwr_q;
  logic [31:0]                 rdata_q;
  logic                        rvalid_q;
  logic [NUM_PORTS-1:0]        port_q;
  logic [EP_W:0]               rx_ep_q;
  logic                        rx_ep_valid_q;

  // Write decode; every access is one whole word
  wire wr_serial = reg_wr_i & (reg_addr_i == SERIAL_CTRL_OFS);
  wire wr_flags  = reg_wr_i & (reg_addr_i == EVENT_FLAGS_OFS);
  wire wr_hold   = reg_wr_i & (reg_addr_i == HOLD_SEL_OFS);
  wire wr_mask   = reg_wr_i & (reg_addr_i == PORT_MASK_OFS);
  wire wr_frame  = reg_wr_i & (reg_addr_i == FRAME_COUNT_OFS);
  wire wr_mark   = reg_wr_i & (reg_addr_i == EP_MARK_OFS);
  wire wr_sess   = reg_wr_i & (reg_addr_i == SESS_MASK_OFS);
  wire wr_pwr    = reg_wr_i & (reg_addr_i == PWR_SIG_OFS);

  // Writing one to a flag bit clears it
  wire [NUM_FLAGS-1:0] flag_clr = wr_flags ? reg_wdata_i[NUM_FLAGS-1:0]
                                           : '0;

  // Flag sources
  logic [NUM_FLAGS-1:0] flag_hit;
  logic [NUM_FLAGS-1:0] flag_w;

  assign flag_hit[TOKEN_FLAG_BIT] = token_ok_i;
  assign flag_hit[SE0_FLAG_BIT]   = (ls_s == LS_SE0);
  assign flag_hit[K_FLAG_BIT]     = (ls_s == LS_K);
  assign flag_hit[J_FLAG_BIT]     = (ls_s == LS_J);
  assign flag_hit[CRC_FLAG_BIT]   = crc16_fail_i;
  assign flag_hit[RXACT_FLAG_BIT] = rx_act_s;
  assign flag_hit[RXERR_FLAG_BIT] = rx_err_s;

  // Pulse flags clear at packet start unless held; level flags track their
  // source while not held, and latch ones while held
  genvar gi;
  generate
    for (gi = 0; gi < NUM_FLAGS; gi++) begin : g_flag
      uim_flag_cell #(
        .LEVEL (gi != TOKEN_FLAG_BIT && gi != CRC_FLAG_BIT)
      ) u_cell (
        .clk_i       (clk_i),
        .reset_i     (reset_i),
        .hit_i       (flag_hit[gi]),
        .sticky_i    (hold_q[gi]),
        .pkt_start_i (pkt_start_i),
        .clear_i     (flag_clr[gi]),
        .flag_o      (flag_w[gi])
      );
    end
  endgenerate

  // Mask combination, registered so ports come from flops
  logic [NUM_PORTS-1:0] port_d;
  generate
    for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
      assign port_d[gi] =
        |(mask_q[gi*MASK_W +: MASK_W] & {1'b0, flag_w});
    end
  endgenerate

  // Endpoint delivered with mark applied
  wire [EP_W:0] rx_ep_d = mark_q[ep_i] ? ({1'b0, ep_i} | EP_MARK_OR)
                                       : {1'b0, ep_i};

  // Frame count: a received frame number wins over a software write
  wire [FRAME_W-1:0] frame_d = sof_valid_i ? sof_frame_i
                             : wr_frame    ? reg_wdata_i[FRAME_W-1:0]
                             : frame_q;

  // Read mux; unmapped offsets and reserved bits read as zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    unique case (reg_addr_i)
      OTG_STATUS_OFS:  rd_mux[OTG_STATUS_W-1:0] = otg_s;
      SERIAL_CTRL_OFS: rd_mux[RX_DIFF_BIT:0] = {rx_lvl_s, serial_q};
      EVENT_FLAGS_OFS: rd_mux[NUM_FLAGS-1:0] = flag_w;
      HOLD_SEL_OFS:    rd_mux[NUM_FLAGS-1:0] = hold_q;
      PORT_MASK_OFS:   rd_mux = mask_q;
      FRAME_COUNT_OFS: rd_mux[FRAME_W-1:0] = frame_q;
      LAST_PID_OFS:    rd_mux[PID_W-1:0] = pid_q;
      LAST_EP_OFS:     rd_mux[EP_W:0] = last_ep_q;
      EP_MARK_OFS:     rd_mux[EP_MARK_W-1:0] = mark_q;
      SESS_MASK_OFS:   rd_mux = sess_mask_q;
      PWR_SIG_OFS:     rd_mux[PWR_SIG_W-1:0] = pwr_q;
      default:         rd_mux = '0;
    endcase
  end

  // Software-owned registers
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      serial_q    <= SERIAL_CTRL_RESET;
      hold_q      <= '0;
      mask_q      <= '0;
      mark_q      <= '0;
      sess_mask_q <= '0;
      pwr_q       <= '0;
    end else begin
      if (wr_serial) serial_q <= reg_wdata_i[SERIAL_CTRL_W-1:0];
      if (wr_hold) hold_q <= reg_wdata_i[NUM_FLAGS-1:0];
      if (wr_mask) mask_q <= reg_wdata_i;
      if (wr_mark) mark_q <= reg_wdata_i[EP_MARK_W-1:0];
      if (wr_sess) sess_mask_q <= reg_wdata_i;
      if (wr_pwr) pwr_q <= reg_wdata_i[PWR_SIG_W-1:0];
    end
  end

  // Packet-decoder captured state
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      frame_q       <= '0;
      pid_q         <= '0;
      last_ep_q     <= '0;
      rx_ep_q       <= '0;
      rx_ep_valid_q <= 1'b0;
    end else begin
      frame_q       <= frame_d;
      rx_ep_valid_q <= ep_valid_i;
      if (pid_valid_i) pid_q <= pid_i;
      if (ep_valid_i) begin
        last_ep_q <= {1'b1, ep_i};
        rx_ep_q   <= rx_ep_d;
      end
    end
  end

  // Read data and ports
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_q  <= '0;
      rvalid_q <= 1'b0;
      port_q   <= '0;
    end else begin
      rvalid_q <= reg_rd_i;
      rdata_q  <= reg_rd_i ? rd_mux : rdata_q;
      port_q   <= port_d;
    end
  end

  assign reg_rdata_o        = rdata_q;
  assign reg_rvalid_o       = rvalid_q;
  assign tx_se0_o           = serial_q[TX_SE0_BIT];
  assign tx_data_o          = serial_q[TX_DATA_BIT];
  assign tx_enable_n_o      = serial_q[TX_EN_LOW_BIT];
  assign fsls_serial_o      = serial_q[FSLS_BIT];
  assign port_1n_o          = port_q[0];
  assign port_1o_o          = port_q[1];
  assign port_1p_o          = port_q[2];
  assign port_extra_o       = port_q[3];
  assign rx_ep_o            = rx_ep_q;
  assign rx_ep_valid_o      = rx_ep_valid_q;
  assign pwr_signal_valid_o = pwr_q[PWR_VALID_BIT];
  assign pwr_signal_value_o = pwr_q[7:0];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  otg_mirror_a: assert property (
    reg_rd_i && reg_addr_i == OTG_STATUS_OFS |=>
      reg_rdata_o == {26'h0, $past(otg_s)})
    else $error("session status readback wrong");

  serial_levels_a: assert property (
    reg_rd_i && reg_addr_i == SERIAL_CTRL_OFS |=>
      reg_rdata_o[6:4] == $past(rx_lvl_s) && reg_rdata_o[31:7] == '0)
    else $error("receive levels readback wrong");

  tx_control_a: assert property (
    wr_serial |=> tx_enable_n_o == $past(reg_wdata_i[1])
              && tx_se0_o == $past(reg_wdata_i[3])
              && fsls_serial_o == $past(reg_wdata_i[0]))
    else $error("transmit controls not loaded");

  tx_data_a: assert property (
    wr_serial |=> tx_data_o == $past(reg_wdata_i[TX_DATA_BIT]))
    else $error("transmit data not loaded");

  auto_clear_a: assert property (
    pkt_start_i && !hold_q[CRC_FLAG_BIT] && !crc16_fail_i |=>
      !flag_w[CRC_FLAG_BIT])
    else $error("flag not cleared at packet start");

  token_set_a: assert property (
    token_ok_i |=> flag_w[TOKEN_FLAG_BIT])
    else $error("token flag not set");

  level_drop_a: assert property (
    !hold_q[SE0_FLAG_BIT] && ls_s != LS_SE0 |=> !flag_w[SE0_FLAG_BIT])
    else $error("line flag not overwritten");

  line_flags_a: assert property (
    ls_s == LS_K |=> flag_w[K_FLAG_BIT] && !flag_w[SE0_FLAG_BIT]
                     || hold_q[SE0_FLAG_BIT] || $past(hold_q[SE0_FLAG_BIT]))
    else $error("line state flags wrong");

  crc_set_a: assert property (
    crc16_fail_i |=> flag_w[CRC_FLAG_BIT])
    else $error("crc flag not set");

  rx_follow_a: assert property (
    !hold_q[RXACT_FLAG_BIT] |=> flag_w[RXACT_FLAG_BIT] == $past(rx_act_s))
    else $error("receive active flag not following");

  hold_keep_a: assert property (
    hold_q[TOKEN_FLAG_BIT] && flag_w[TOKEN_FLAG_BIT]
      && !flag_clr[TOKEN_FLAG_BIT] |=> flag_w[TOKEN_FLAG_BIT])
    else $error("held flag lost");

  hold_clear_a: assert property (
    wr_flags && reg_wdata_i[TOKEN_FLAG_BIT] && !token_ok_i |=>
      !flag_w[TOKEN_FLAG_BIT])
    else $error("write one did not clear flag");

  port_or_a: assert property (
    ##1 port_1p_o == |($past(mask_q[23:16]) & {1'b0, $past(flag_w)}))
    else $error("port mask combination wrong");

  port_1n_a: assert property (
    ##1 port_1n_o == |($past(mask_q[MASK_W-1:0]) & {1'b0, $past(flag_w)}))
    else $error("first port combination wrong");

  port_1o_a: assert property (
    ##1 port_1o_o ==
      |($past(mask_q[2*MASK_W-1:MASK_W]) & {1'b0, $past(flag_w)}))
    else $error("second port combination wrong");

  frame_load_a: assert property (
    sof_valid_i |=> frame_q == $past(sof_frame_i))
    else $error("frame count not loaded");

  pid_cap_a: assert property (
    pid_valid_i |=> pid_q == $past(pid_i))
    else $error("packet id not captured");

  ep_cap_a: assert property (
    ep_valid_i |=> last_ep_q == {1'b1, $past(ep_i)})
    else $error("endpoint not captured");

  ep_mark_a: assert property (
    ep_valid_i |=> rx_ep_o[4] == $past(mark_q[ep_i])
                && rx_ep_o[3:0] == $past(ep_i) && rx_ep_valid_o)
    else $error("marked endpoint wrong");

endmodule : uim_status_flags
`default_nettype wire

// ==== tb/uim_phy_model.sv ====
// Behavioural transceiver and packet decoder facing the status block.
// Assumes the bench calls its tasks; outputs change at falling edges.
`timescale 1ns/100ps
`default_nettype none
module uim_phy_model
  import uim_pkg::*;
(
  input  wire logic               clk_i,
  output logic [OTG_STATUS_W-1:0] otg_status_o,
  output logic [2:0]              rx_lines_o,
  output logic [1:0]              line_state_o,
  output logic [1:0]              rx_act_err_o,
  output logic [5:0]              strobe_o,
  output logic [FRAME_W-1:0]      value_o
);
  // Line state 3 is no symbol, so no line flag is raised at start
  initial begin
    otg_status_o = '0;
    rx_lines_o   = 3'h0;
    line_state_o = 2'h3;
    rx_act_err_o = 2'h0;
    strobe_o     = 6'h0;
    value_o      = '0;
  end

  // rx_lines_o is {diff, dm, dp}; rx_act_err_o is {active, error}
  task automatic levels(input logic [5:0] otg, input logic [2:0] rx,
                        input logic [1:0] ls, input logic [1:0] ae);
    @(negedge clk_i);
    otg_status_o = otg;
    rx_lines_o   = rx;
    line_state_o = ls;
    rx_act_err_o = ae;
  endtask : levels

  // Strobe order {sof, ep, pid, crc, token, pkt}; one cycle each
  task automatic pulse(input int kind, input logic [10:0] v);
    @(negedge clk_i);
    strobe_o = 6'(1 << kind);
    value_o  = v;
    @(negedge clk_i);
    strobe_o = 6'h0;
    // Data means nothing without its strobe, so it is scrambled
    value_o  = ~v;
  endtask : pulse
endmodule : uim_phy_model
`default_nettype wire

// ==== tb/tb_uim_status_flags.sv ====
// Self-checking bench for the status and flag block.
// Assumes the phy model drives all transceiver and decoder inputs.
`timescale 1ns/100ps
`default_nettype none
module tb_uim_status_flags
  import uim_pkg::*;
;
  logic        clk_i     = 1'b0;
  logic        reset_i   = 1'b1;
  logic [7:0]  reg_addr  = 8'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [31:0] reg_rdata;
  logic        reg_rvalid;
  logic [5:0]  otg;
  logic [2:0]  rxl;
  logic [1:0]  ls;
  logic [1:0]  ae;
  logic [5:0]  stb;
  logic [10:0] val;
  wire  [3:0]  tx;
  wire  [3:0]  ports;
  logic [4:0]  rx_ep;
  logic        rx_ep_valid;
  wire  [8:0]  pwr;
  int          mismatches = 0;
  int          samples_checked = 0;

  uim_phy_model i_phy (.clk_i(clk_i), .otg_status_o(otg),
    .rx_lines_o(rxl), .line_state_o(ls), .rx_act_err_o(ae),
    .strobe_o(stb), .value_o(val));

  uim_status_flags i_dut (.clk_i(clk_i), .reset_i(reset_i),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .reg_rvalid_o(reg_rvalid),
    .otg_status_i(otg), .rx_diff_i(rxl[2]), .rx_dm_i(rxl[1]),
    .rx_dp_i(rxl[0]), .line_state_i(ls), .rx_active_i(ae[1]),
    .rx_error_i(ae[0]), .pkt_start_i(stb[0]), .token_ok_i(stb[1]),
    .crc16_fail_i(stb[2]), .pid_valid_i(stb[3]), .pid_i(val[3:0]),
    .ep_valid_i(stb[4]), .ep_i(val[3:0]), .sof_valid_i(stb[5]),
    .sof_frame_i(val), .tx_se0_o(tx[3]), .tx_data_o(tx[2]),
    .tx_enable_n_o(tx[1]), .fsls_serial_o(tx[0]), .port_1n_o(ports[0]),
    .port_1o_o(ports[1]), .port_1p_o(ports[2]), .port_extra_o(ports[3]),
    .rx_ep_o(rx_ep), .rx_ep_valid_o(rx_ep_valid),
    .pwr_signal_valid_o(pwr[8]), .pwr_signal_value_o(pwr[7:0]));

  initial begin
    forever #20 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test

  // Whole 32-bit words only; strobe held across its one taking edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk_i);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk_i);
    reg_wr    = 1'b0;
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    int i;
    @(negedge clk_i);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clk_i);
    reg_rd   = 1'b0;
    for (i = 0; i < 4; i++) begin
      if (reg_rvalid === 1'b1) break;
      @(negedge clk_i);
    end
    chk(reg_rdata, e);
    if (i == 4) begin
      mismatches++;
      end_of_test();
    end
  endtask : rchk

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_i);
  endtask : wait_n

  task automatic t_reset;
    for (int o = 'h14; o <= 'h44; o += 4)
      rchk(8'(o), (o == 'h18) ? 32'h2 : 32'h0);
    chk({28'h0, tx}, 32'h2);
    chk({28'h0, ports}, 32'h0);
    $display("Test reset values done");
  endtask : t_reset

  task automatic t_serial;
    i_phy.levels(6'h2a, 3'b101, 2'h3, 2'h0);
    wait_n(6);
    rchk(OTG_STATUS_OFS, 32'h2a);
    wr(OTG_STATUS_OFS, 32'hffffffff);
    rchk(OTG_STATUS_OFS, 32'h2a);
    wr(SERIAL_CTRL_OFS, 32'hffffffff);
    rchk(SERIAL_CTRL_OFS, 32'h5f);
    chk({28'h0, tx}, 32'hf);
    wr(SERIAL_CTRL_OFS, 32'h9);
    wait_n(2);
    chk({28'h0, tx}, 32'h9);
    i_phy.levels(6'h15, 3'b010, 2'h3, 2'h0);
    wait_n(6);
    rchk(OTG_STATUS_OFS, 32'h15);
    rchk(SERIAL_CTRL_OFS, 32'h29);
    wr(SERIAL_CTRL_OFS, 32'h2);
    $display("Test serial and session status done");
  endtask : t_serial

  task automatic t_flags;
    wr(PORT_MASK_OFS, 32'h08040240);
    i_phy.pulse(1, 11'h0);
    wait_n(3);
    rchk(EVENT_FLAGS_OFS, 32'h40);
    chk({28'h0, ports}, 32'h1);
    i_phy.pulse(2, 11'h0);
    wait_n(3);
    rchk(EVENT_FLAGS_OFS, 32'h44);
    chk({28'h0, ports}, 32'h5);
    i_phy.pulse(0, 11'h0);
    wait_n(3);
    rchk(EVENT_FLAGS_OFS, 32'h0);
    chk({28'h0, ports}, 32'h0);
    i_phy.levels(6'h0, 3'h0, LS_SE0, 2'h0);
    wait_n(6);
    rchk(EVENT_FLAGS_OFS, 32'h20);
    i_phy.levels(6'h0, 3'h0, LS_K, 2'h0);
    wait_n(6);
    rchk(EVENT_FLAGS_OFS, 32'h10);
    i_phy.levels(6'h0, 3'h0, LS_J, 2'h2);
    wait_n(6);
    rchk(EVENT_FLAGS_OFS, 32'h0a);
    chk({28'h0, ports}, 32'ha);
    i_phy.levels(6'h0, 3'h0, 2'h3, 2'h1);
    wait_n(6);
    rchk(EVENT_FLAGS_OFS, 32'h01);
    i_phy.levels(6'h0, 3'h0, 2'h3, 2'h0);
    wait_n(6);
    rchk(EVENT_FLAGS_OFS, 32'h0);
    $display("Test flags and masks done");
  endtask : t_flags

  task automatic t_sticky;
    wr(HOLD_SEL_OFS, 32'hffffff41);
    rchk(HOLD_SEL_OFS, 32'h41);
    i_phy.pulse(1, 11'h0);
    i_phy.pulse(0, 11'h0);
    wait_n(3);
    rchk(EVENT_FLAGS_OFS, 32'h40);
    i_phy.levels(6'h0, 3'h0, 2'h3, 2'h1);
    wait_n(6);
    i_phy.levels(6'h0, 3'h0, 2'h3, 2'h0);
    wait_n(6);
    rchk(EVENT_FLAGS_OFS, 32'h41);
    wr(EVENT_FLAGS_OFS, 32'h40);
    rchk(EVENT_FLAGS_OFS, 32'h01);
    wr(EVENT_FLAGS_OFS, 32'h01);
    rchk(EVENT_FLAGS_OFS, 32'h0);
    wr(HOLD_SEL_OFS, 32'h0);
    $display("Test held flags done");
  endtask : t_sticky

  task automatic t_decode;
    wr(FRAME_COUNT_OFS, 32'hffffffff);
    rchk(FRAME_COUNT_OFS, 32'h7ff);
    i_phy.pulse(5, 11'h123);
    rchk(FRAME_COUNT_OFS, 32'h123);
    i_phy.pulse(3, 11'h00a);
    wr(LAST_PID_OFS, 32'h5);
    rchk(LAST_PID_OFS, 32'ha);
    wr(EP_MARK_OFS, 32'hffff0020);
    rchk(EP_MARK_OFS, 32'h20);
    i_phy.pulse(4, 11'h005);
    chk({26'h0, rx_ep_valid, rx_ep}, 32'h35);
    rchk(LAST_EP_OFS, 32'h15);
    i_phy.pulse(4, 11'h003);
    chk({26'h0, rx_ep_valid, rx_ep}, 32'h23);
    rchk(LAST_EP_OFS, 32'h13);
    wr(PWR_SIG_OFS, 32'hfffff1a5);
    wait_n(2);
    chk({23'h0, pwr}, 32'h1a5);
    wr(SESS_MASK_OFS, 32'h5a5ac3c3);
    rchk(SESS_MASK_OFS, 32'h5a5ac3c3);
    wr(8'h44, 32'hffffffff);
    rchk(8'h44, 32'h0);
    $display("Test decoder capture done");
  endtask : t_decode

  initial begin
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    reset_i = 1'b0;
    wait_n(4);
    t_reset();
    t_serial();
    t_flags();
    t_sticky();
    t_decode();
    end_of_test();
  end
endmodule : tb_uim_status_flags
`default_nettype wire
